// >>> logic/esp_pkg.sv
// constants and types shared by the serial position port
package esp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POS_BITS = 20;
  localparam int RES_MIN = 12;
  localparam int CRC_BITS = 6;
  localparam int IDX_W = 6;
  localparam int TMR_W = 12;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_INIT = 6'h00;
  localparam logic [5:0] IDX_DONE = 6'h3F;
  localparam logic [5:0] BISS_TAIL = 6'h0A;
  localparam logic [5:0] BISS_POS_BASE = 6'h08;
  localparam logic [5:0] BISS_ERR_POS = 6'h07;
  localparam logic [5:0] BISS_WARN_POS = 6'h06;
  localparam logic WARN_DEFAULT = 1'h1;
  localparam logic ACK_LEVEL = 1'h0;
  localparam logic START_LEVEL = 1'h1;
  localparam logic FOLLOW_LEVEL = 1'h0;
  localparam logic DATA_IDLE = 1'h1;
  localparam logic DATA_QUIET = 1'h0;
  // frame_quiet_hold_time and link timeout, in microseconds
  localparam int MONO_US = 25;
  localparam logic [11:0] QUIET_CYC = 12'(MONO_US * 1000 / CLK_PERIOD_NS);
  // request_gap_time least value, microseconds (kept by the master)
  localparam int REQ_GAP_US = 26;
  // bit_refresh_delay, longest, in nanoseconds
  localparam int BIT_UPDATE_NS = 90;
  localparam int UPD_CYC = BIT_UPDATE_NS / CLK_PERIOD_NS;
  // position refresh rates in hertz
  localparam int REFRESH_SLOW_HZ = 35000;
  localparam int REFRESH_FAST_HZ = 375000;
  localparam logic [11:0] REFRESH_SLOW_CYC =
    12'(1000000000 / (REFRESH_SLOW_HZ * CLK_PERIOD_NS));
  localparam logic [11:0] REFRESH_FAST_CYC =
    12'(1000000000 / (REFRESH_FAST_HZ * CLK_PERIOD_NS));
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [1:0] {
    IDLE_S = 2'h0,
    SHIFT_S = 2'h1,
    HOLD_S = 2'h3,
    SERVICE_S = 2'h2
  } esp_state_t;
endpackage : esp_pkg

// >>> logic/esp_word_if.sv
// valid/ready word carrier between the port's own modules
`timescale 1ns/1ps
interface esp_word_if #(parameter int W = 20) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : esp_word_if

// >>> logic/esp_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module esp_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } esp_sync_t;
  esp_sync_t st;
  esp_sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : esp_sync

// >>> logic/esp_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module esp_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic nrst,
  esp_word_if.snk wr,
  esp_word_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } esp_fifo_t;
  esp_fifo_t st;
  esp_fifo_t next_st;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (st.wp == st.rp);
  assign full = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = st.mem[st.rp[AW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  always_comb begin
    next_st = st;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && (st.wp[AW-1:0] == AW'(i))) begin
        next_st.mem[i] = wr.data;
      end
    end
    if (push) begin
      next_st.wp = st.wp + (AW+1)'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : esp_fifo

// >>> logic/esp_port.sv
// serial absolute position port: ssi and biss-c slave with service mode
// How it works
// - wake up in position mode, not service
// - refresh position at 35 or 375 kHz
// - ssi error flag one on fault
// - ssi without test option sends position only
// - bits follow edges quickly; master spaces requests
// - slave shifts on the master's clock only
// - biss acknowledge sends zero for one clock
// - start bit one, then a zero bit
// - frame positions scale with resolution
// - biss error flag one means healthy
// - warning bit always sent as one
// - crc six over position, error, warning
// - crc sent msb first and inverted
// - start and zero bits skip the crc
// - 25 us quiet time after each frame
// - service mode reuses clock and data pairs
`timescale 1ns/1ps
module esp_port (
  input wire logic clock,
  input wire logic nrst,
  input wire logic link_clk_pin,
  input wire logic [esp_pkg::POS_BITS-1:0] pos_sample,
  input wire logic pos_valid,
  output logic pos_ready,
  input wire logic fault_in,
  input wire logic biss_sel,
  input wire logic bit_option,
  input wire logic fast_rate,
  input wire logic [4:0] res_bits,
  input wire logic service_req,
  input wire logic service_tx,
  output logic data_out,
  output logic service_rx,
  output logic frame_busy
);
  import esp_pkg::*;

  typedef struct packed {
    esp_state_t state;
    logic data;
    logic clk_q;
    logic [IDX_W-1:0] idx;
    logic [TMR_W-1:0] timer;
    logic [CRC_BITS-1:0] crc;
    logic [POS_BITS-1:0] sample;
    logic fault;
    logic biss;
    logic opt;
    logic [4:0] nbits;
    logic [TMR_W-1:0] refresh;
    logic [POS_BITS-1:0] pos_now;
  } esp_core_t;

  esp_core_t st;
  esp_core_t next_st;
  logic link_clk_s;
  logic rise;
  logic fall;
  logic tick;
  logic cur_bit;
  logic crc_cover;
  logic crc_fb;
  logic [IDX_W-1:0] top;
  logic [IDX_W-1:0] pos_idx;

  //////////////////////////////////////////////////////////////////////////
  // link clock sampling and refresh buffer

  esp_sync #(.W(1)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d(link_clk_pin),
    .q(link_clk_s)
  );

  esp_word_if #(.W(POS_BITS)) wr_if ();
  esp_word_if #(.W(POS_BITS)) rd_if ();

  assign wr_if.valid = pos_valid;
  assign wr_if.data = pos_sample;
  assign pos_ready = wr_if.ready;
  assign rd_if.ready = tick;

  esp_fifo #(.W(POS_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .wr(wr_if.snk),
    .rd(rd_if.src)
  );

  //////////////////////////////////////////////////////////////////////////
  // frame layout

  function automatic logic [IDX_W-1:0] frame_top(input logic biss, input logic opt,
                                                input logic [4:0] n);
    if (biss) begin
      frame_top = IDX_W'(n) + BISS_TAIL;
    end else begin
      frame_top = IDX_W'(n) - IDX_W'(1) + IDX_W'(opt);
    end
  endfunction : frame_top

  // edges only, the master owns the clock
  assign rise = link_clk_s && !st.clk_q;
  assign fall = !link_clk_s && st.clk_q;
  assign tick = (st.refresh == '0);
  assign top = frame_top(st.biss, st.opt, st.nbits);
  assign pos_idx = st.idx - (st.biss ? BISS_POS_BASE : IDX_W'(st.opt));
  // start and zero bits stay outside the covered span
  assign crc_cover = st.biss && (st.idx >= BISS_WARN_POS) && (st.idx <= top - IDX_W'(3));
  assign crc_fb = st.crc[CRC_BITS-1] ^ cur_bit;

  always_comb begin
    cur_bit = DATA_IDLE;
    if (st.biss) begin
      if (st.idx == top) begin
        cur_bit = ACK_LEVEL;
      end else if (st.idx == top - IDX_W'(1)) begin
        cur_bit = START_LEVEL;
      end else if (st.idx == top - IDX_W'(2)) begin
        cur_bit = FOLLOW_LEVEL;
      end else if (st.idx >= BISS_POS_BASE) begin
        cur_bit = st.sample[pos_idx[4:0]];
      end else if (st.idx == BISS_ERR_POS) begin
        cur_bit = st.opt ? !st.fault : 1'h1;
      end else if (st.idx == BISS_WARN_POS) begin
        cur_bit = WARN_DEFAULT;
      end else begin
        cur_bit = !st.crc[st.idx[2:0]];
      end
    end else begin
      if (st.opt && (st.idx == '0)) begin
        cur_bit = st.fault;
      end else begin
        cur_bit = st.sample[pos_idx[4:0]];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.clk_q = link_clk_s;
    if (tick) begin
      next_st.refresh = fast_rate ? REFRESH_FAST_CYC - 12'h1 : REFRESH_SLOW_CYC - 12'h1;
      if (rd_if.valid) begin
        next_st.pos_now = rd_if.data;
      end
    end else begin
      next_st.refresh = st.refresh - 12'h1;
    end
    unique case (st.state)
      IDLE_S: begin
        next_st.data = DATA_IDLE;
        if (service_req) begin
          next_st.state = SERVICE_S;
        end else if (fall) begin
          next_st.state = SHIFT_S;
          next_st.sample = st.pos_now;
          next_st.fault = fault_in;
          next_st.biss = biss_sel;
          next_st.opt = bit_option;
          next_st.nbits = res_bits;
          next_st.idx = frame_top(biss_sel, bit_option, res_bits);
          next_st.crc = CRC_INIT;
          next_st.timer = '0;
        end
      end
      SHIFT_S: begin
        next_st.timer = st.timer + 12'h1;
        if (rise || fall) begin
          next_st.timer = '0;
        end
        if (rise) begin
          if (st.idx == IDX_DONE) begin
            next_st.state = HOLD_S;
            next_st.data = DATA_QUIET;
          end else begin
            next_st.data = cur_bit;
            next_st.idx = st.idx - IDX_W'(1);
            if (crc_cover) begin
              next_st.crc = {st.crc[CRC_BITS-2:0], 1'h0} ^ (crc_fb ? CRC_POLY : 6'h00);
            end
          end
        end else if (st.timer == QUIET_CYC - 12'h1) begin
          next_st.state = IDLE_S;
          next_st.data = DATA_IDLE;
        end
      end
      HOLD_S: begin
        next_st.timer = st.timer + 12'h1;
        if (st.timer == QUIET_CYC - 12'h1) begin
          next_st.state = IDLE_S;
          next_st.data = DATA_IDLE;
        end
      end
      SERVICE_S: begin
        next_st.data = service_tx;
        if (!service_req) begin
          next_st.state = IDLE_S;
          next_st.data = DATA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '{state: IDLE_S, data: DATA_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.data;
  assign service_rx = link_clk_s;
  assign frame_busy = (st.state == SHIFT_S) || (st.state == HOLD_S);

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence rise_sh;
    rise && (st.state == SHIFT_S) && (st.idx != IDX_DONE);
  endsequence

  sequence biss_at(logic [IDX_W-1:0] k);
    rise_sh ##0 st.biss && (st.idx == k);
  endsequence

  sequence req_fall;
    fall && (st.state == IDLE_S) && !service_req;
  endsequence

  power_up_mode_a: assert property ($rose(nrst) |-> st.state == IDLE_S && data_out)
    else $error("not in position mode after reset");

  refresh_period_a: assert property (tick |=> st.refresh ==
    (fast_rate ? REFRESH_FAST_CYC : REFRESH_SLOW_CYC) - 12'h1
    || $past(fast_rate) != fast_rate)
    else $error("refresh period wrong");

  ssi_flag_a: assert property (rise_sh ##0 !st.biss && st.opt && st.idx == '0
    |=> data_out == st.fault)
    else $error("ssi error flag wrong");

  ssi_plain_a: assert property (fall && st.state == IDLE_S && !biss_sel && !bit_option
    && !service_req |=> st.idx == IDX_W'(res_bits) - IDX_W'(1))
    else $error("ssi frame length wrong");

  bit_follow_a: assert property (rise_sh |=> data_out == $past(cur_bit))
    else $error("bit not driven after edge");

  biss_ack_a: assert property (rise_sh ##0 st.biss && st.idx == top |=> !data_out)
    else $error("acknowledge not zero");

  biss_start_a: assert property (biss_at(top - IDX_W'(1)) |=> data_out)
    else $error("start bit not one");

  biss_follow_a: assert property (biss_at(top - IDX_W'(2)) |=> !data_out)
    else $error("start follower not zero");

  biss_len_a: assert property (fall && st.state == IDLE_S && biss_sel && !service_req
    |=> st.idx == IDX_W'(res_bits) + BISS_TAIL)
    else $error("biss frame top wrong");

  biss_err_a: assert property (biss_at(BISS_ERR_POS)
    |=> data_out == (!st.opt || !st.fault))
    else $error("biss error flag wrong");

  biss_warn_a: assert property (biss_at(BISS_WARN_POS) |=> data_out)
    else $error("warning bit not one");

  crc_hold_a: assert property (rise_sh ##0 st.biss && st.idx < BISS_WARN_POS
    |=> $stable(st.crc))
    else $error("crc changed during crc field");

  quiet_end_a: assert property (st.state == HOLD_S && st.timer == QUIET_CYC - 12'h1
    |=> st.state == IDLE_S && data_out)
    else $error("quiet time end wrong");

  service_tx_a: assert property (st.state == SERVICE_S && service_req
    |=> data_out == $past(service_tx))
    else $error("service transmit not passed");

  sample_hold_a: assert property (st.state == SHIFT_S |=> $stable(st.sample))
    else $error("sample changed in frame");

  frame_open_a: assert property (req_fall |=> st.state == SHIFT_S
    && st.sample == $past(st.pos_now))
    else $error("frame did not latch position");

  cut_frame_a: assert property (st.state == SHIFT_S && st.timer == QUIET_CYC - 12'h1
    && !rise && !fall |=> st.state == IDLE_S && data_out)
    else $error("cut frame not abandoned");
endmodule : esp_port

// >>> tb/esp_link_master.sv
// behavioural link master that clocks frames out of the port
`timescale 1ns/1ps
module esp_link_master (
  output logic link_clk_pin,
  input wire logic data_out
);
  initial begin
    link_clk_pin = 1'b1;
  end
  ////////////////////////////////////////
  // one request: fall, nrise rising edges, each bit read late in its period
  task automatic run_frame(input int nrise, output logic [63:0] bits);
    bits = '0;
    link_clk_pin = 1'b0;
    #40;
    for (int k = 0; k < nrise; k++) begin
      link_clk_pin = 1'b1;
      #40;
      link_clk_pin = 1'b0;
      #35;
      bits = {bits[62:0], data_out};
      #5;
    end
    link_clk_pin = 1'b1;
  endtask : run_frame
  // a single stray request edge
  task automatic pulse();
    link_clk_pin = 1'b0;
    #40;
    link_clk_pin = 1'b1;
  endtask : pulse
endmodule : esp_link_master

// >>> tb/tb_top.sv
// self-checking bench for the serial position port
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED at %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import esp_pkg::*;
  localparam int LIMIT = 60000;
  logic clock, nrst, link_clk_pin, pos_valid, pos_ready, fault_in, biss_sel;
  logic bit_option, fast_rate, service_req, service_tx, data_out, service_rx, frame_busy;
  logic [POS_BITS-1:0] pos_sample;
  logic [4:0] res_bits;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int res_tab[8] = '{12, 20, 17, 13, 19, 20, 12, 18};
  esp_port i_esp_port (.clock(clock), .nrst(nrst), .link_clk_pin(link_clk_pin),
    .pos_sample(pos_sample), .pos_valid(pos_valid), .pos_ready(pos_ready),
    .fault_in(fault_in), .biss_sel(biss_sel), .bit_option(bit_option),
    .fast_rate(fast_rate), .res_bits(res_bits), .service_req(service_req),
    .service_tx(service_tx), .data_out(data_out), .service_rx(service_rx),
    .frame_busy(frame_busy));
  esp_link_master i_esp_link_master (.link_clk_pin(link_clk_pin), .data_out(data_out));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
    return {c[4:0], 1'b0} ^ ((c[5] ^ b) ? CRC_POLY : 6'h00);
  endfunction : crc_step
  function automatic logic [63:0] exp_frame(input logic [POS_BITS-1:0] p, input int n,
      input logic biss, input logic opt, input logic flt);
    logic [63:0] v;
    logic [5:0] c;
    logic e;
    v = biss ? 64'h2 : 64'h0;
    c = CRC_INIT;
    e = opt ? ~flt : 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      v = {v[62:0], p[i]};
      c = crc_step(c, p[i]);
    end
    if (biss) begin
      c = crc_step(crc_step(c, e), WARN_DEFAULT);
      v = {v[55:0], e, WARN_DEFAULT, ~c};
    end else if (opt) begin
      v = {v[62:0], flt};
    end
    return v;
  endfunction : exp_frame
  // entered just after a rising edge; valid is left at keep once taken
  task automatic push(input logic [POS_BITS-1:0] w, input logic keep);
    int k;
    k = 0;
    pos_sample <= w;
    if (pos_valid !== 1'b1) pos_valid <= 1'b1;
    do begin
      @(negedge clock);
      k++;
    end while (pos_ready !== 1'b1 && k < 4000);
    @(posedge clock);
    pos_valid <= keep;
  endtask : push
  task automatic wait_ready(output int t);
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (pos_ready !== 1'b1 && k < 4000);
    t = cyc;
  endtask : wait_ready
  ////////////////////////////////////////
  task automatic rate_test(input logic fast, input int per);
    int t0, t1, d;
    @(posedge clock);
    fast_rate <= fast;
    for (int i = 0; i < FIFO_DEPTH; i++) push(20'($urandom), i < FIFO_DEPTH - 1);
    @(negedge clock);
    `CHK(pos_ready, 1'b0)
    wait_ready(t0);
    @(posedge clock);
    push(20'($urandom), 1'b0);
    wait_ready(t1);
    d = t1 - t0;
    `CHK(d >= per - 1 && d <= per + 1, 1'b1)
    $display("refresh test period %0d done", per);
  endtask : rate_test
  task automatic frame_test(input int k);
    logic [63:0] got, expv;
    logic [POS_BITS-1:0] p;
    int n, nb;
    n = res_tab[k];
    p = POS_BITS'($urandom) & ((20'h1 << n) - 20'h1);
    nb = k[0] ? n + 11 : n + int'(k[1]);
    @(posedge clock);
    biss_sel <= k[0];
    bit_option <= k[1];
    fault_in <= k[2];
    res_bits <= 5'(n);
    fast_rate <= 1'b1;
    push(p, 1'b0);
    repeat (600) @(posedge clock);
    expv = exp_frame(p, n, k[0], k[1], k[2]);
    #3;
    fork
      i_esp_link_master.run_frame(nb, got);
      begin
        repeat (40) @(posedge clock);
        fault_in <= ~k[2];
        push(20'($urandom), 1'b0);
      end
    join
    `CHK(got, expv)
    #50;
    `CHK(data_out, DATA_QUIET)
    i_esp_link_master.pulse();
    #100;
    `CHK(data_out, DATA_QUIET)
    `CHK(frame_busy, 1'b1)
    repeat (2600) @(posedge clock);
    @(negedge clock);
    `CHK(data_out, DATA_IDLE)
    `CHK(frame_busy, 1'b0)
    $display("frame test %0d done", k);
  endtask : frame_test
  task automatic service_test();
    logic [7:0] r;
    r = 8'($urandom);
    i_esp_link_master.pulse();
    repeat (20) @(posedge clock);
    @(negedge clock);
    `CHK(frame_busy, 1'b1)
    repeat (2600) @(posedge clock);
    @(negedge clock);
    `CHK(frame_busy, 1'b0)
    `CHK(data_out, DATA_IDLE)
    @(posedge clock);
    service_req <= 1'b1;
    repeat (3) @(posedge clock);
    i_esp_link_master.pulse();
    repeat (9) @(posedge clock);
    @(negedge clock);
    `CHK(frame_busy, 1'b0)
    `CHK(service_rx, 1'b1)
    @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      service_tx <= r[i];
      @(negedge clock);
      if (i > 0) `CHK(data_out, r[i - 1])
      @(posedge clock);
    end
    service_req <= 1'b0;
    @(negedge clock);
    `CHK(data_out, r[7])
    repeat (3) @(posedge clock);
    @(negedge clock);
    `CHK(data_out, DATA_IDLE)
    $display("service test done");
  endtask : service_test
  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    pos_valid = 1'b0;
    pos_sample = '0;
    fault_in = 1'b0;
    biss_sel = 1'b0;
    bit_option = 1'b0;
    fast_rate = 1'b0;
    res_bits = 5'h14;
    service_req = 1'b0;
    service_tx = 1'b0;
    void'($urandom(32'hB822));
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    `CHK(data_out, DATA_IDLE)
    `CHK(frame_busy, 1'b0)
    `CHK(pos_ready, 1'b1)
    repeat (4) @(posedge clock);
    rate_test(1'b0, int'(REFRESH_SLOW_CYC));
    rate_test(1'b1, int'(REFRESH_FAST_CYC));
    repeat (1200) @(posedge clock);
    for (int k = 0; k < 8; k++) frame_test(k);
    service_test();
    close_out();
  end
endmodule : tb_top
